// ==== design/sampler_message_decoder.v ====
// sampler request message decoder: descriptor and header interpretation
//
// Overview of operation
// (R1) two-bit width field selects lane count
// (R2) four-bit type field selects sampling operation
// (R3) sampler index ignored for load/info types
// (R4) requester keeps deinterlace/8x8 index alignment
// (R5) eight-bit binding table index selects surface
// (R6) no header means all header fields zero
// (R7) header bits 15:12 mask channel returns
// (R8) requester never masks all four channels
// (R9) signed 4-bit offsets, ignored for some types
// (R10) requester zeroes offsets for cube/buffer surfaces
// (R11) load and surface info parameters are integers
// (R12) omitted trailing parameters read as zero
// (R13) length is header plus width-scaled count
// (R14) requester never exceeds eleven registers
// (R15) response length by width and masks
// (R16) type codes map to fixed parameter lists
// (R17) unused-only registers are never sent
// (R18) wide messages: header plus one, fixed responses
// (R19) eight-by-eight loses four per mask
// (R20) descriptor bit 19 flags header phase
// (R21) length mismatch or overlong flags error
`include "msg_decoder_consts.vh"
`default_nettype none
module sampler_message_decoder (
  input wire REF_CLK,
  input wire RSTN,
  // register-style command port
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // message request
  input wire MSG_VALID,
  input wire [31:0] DESC,
  input wire [31:0] HEADER,
  input wire [3:0] MSG_LEN,
  // decoded outputs, one cycle after request
  output reg DEC_VALID,
  output reg [1:0] LANE_WIDTH,
  output reg [4:0] OP_TYPE,
  output reg [3:0] SAMPLER_IDX,
  output reg [7:0] BIND_IDX,
  output reg [3:0] CHAN_MASK,
  output reg [3:0] OFF_U,
  output reg [3:0] OFF_V,
  output reg [3:0] OFF_R,
  output reg [3:0] PARAMS_SENT,
  output reg INT_PARAMS,
  output reg [4:0] RESP_LEN,
  output reg PROTO_ERR
);
  // register offsets (indices)
  // index 0 is read-only: a write there is dropped on purpose
  localparam [3:0] A_LAST_DESC = `REG_LAST_DESC;
  localparam [3:0] A_ERR_CNT = `REG_ERR_CNT;
  localparam [3:0] A_CTRL = `REG_CTRL;
  localparam [3:0] A_LAST_LEN = `REG_LAST_LEN;

  // field extraction
  // (R20) header phase flag
  wire hdr = DESC[`HDR_PRESENT_BIT];
  // (R1) lane width code
  wire [1:0] width = DESC[`WIDTH_HI:`WIDTH_LO];
  // (R2) operation code
  wire [3:0] typ = DESC[`TYPE_HI:`TYPE_LO];
  // wide codes have a fifth bit the descriptor cannot carry; taken as zero
  wire [4:0] wtyp = {1'b0, typ};
  // full list length, integer class and known-type flag from the table
  wire [3:0] n_full;
  wire int_p;
  wire type_ok;

  // parameter table lookup
  param_count u_pcount (
    .msg_type(typ),
    .n_params(n_full),
    .int_params(int_p),
    .valid_type(type_ok)
  );

  // control: bit0 enables error detection, bit1 forces header zero
  reg [1:0] ctrl_r;
  // software-visible status: last request and running error count
  reg [31:0] last_desc_r;
  reg [15:0] err_cnt_r;
  reg [3:0] last_len_r;

  // combinational decode results
  reg [3:0] mask_nxt;
  reg [3:0] offu_nxt;
  reg [3:0] offv_nxt;
  reg [3:0] offr_nxt;
  reg [3:0] samp_nxt;
  reg [4:0] resp_nxt;
  reg [3:0] sent_nxt;
  // length bookkeeping: registers after the header, rounded full list
  reg len_ok;
  reg [5:0] body;
  reg [5:0] nq;
  // suppressed channels, each one shortens the W_SIXTEEN response and the wide responses other than deinterlace
  reg [2:0] nmask;
  // wide operation classes
  reg wide_e8;
  reg wide_unorm;
  reg wide_deint;
  reg wide_ok;
  reg no_offsets;

  // whole decode is one combinational pass; the result is registered below
  always @* begin
    wide_e8 = 1'b0;
    wide_unorm = 1'b0;
    wide_deint = 1'b0;
    wide_ok = 1'b0;
    body = 6'h00;
    sent_nxt = 4'h0;
    resp_nxt = 5'h00;
    len_ok = 1'b0;
    // (R6) missing header treated as all zero
    if (hdr && !ctrl_r[1]) begin
      // (R7) channel write masks a,b,g,r
      mask_nxt = HEADER[`MASK_A_BIT:`MASK_R_BIT];
      // (R9) signed offsets from header
      offu_nxt = HEADER[`OFFU_HI:`OFFU_LO];
      offv_nxt = HEADER[`OFFV_HI:`OFFV_LO];
      offr_nxt = HEADER[`OFFR_HI:`OFFR_LO];
    end else begin
      mask_nxt = 4'h0;
      offu_nxt = 4'h0;
      offv_nxt = 4'h0;
      offr_nxt = 4'h0;
    end
    // count of masked channels; all four set is the requester's fault
    nmask = {2'b00, mask_nxt[0]} + {2'b00, mask_nxt[1]} + {2'b00, mask_nxt[2]}
      + {2'b00, mask_nxt[3]};
    // (R3) index unused for load and info types
    samp_nxt = DESC[`SAMP_HI:`SAMP_LO];
    if (width != `W_WIDE && (typ == `T_LOAD || typ == `T_SURFINFO || typ == `T_SAMPINFO)) begin
      samp_nxt = 4'h0;
    end
    // rounded list length, only the quad form uses it
    nq = 6'h00;
    case (width)
      // (R13) four-by-two: count rounded up to four
      `W_QUAD: begin
        body = {2'b00, MSG_LEN} - {5'h00, hdr};
        nq = {2'b00, n_full} + 6'h03;
        // (R12) shorter messages allowed, up to full list
        len_ok = type_ok && body != 6'h00 && body <= {2'b00, nq[5:2]};
        // (R17) whole registers of parameters only
        sent_nxt = body[3:0] << 2;
        // (R15) one register back
        resp_nxt = `RESP_QUAD;
      end
      `W_EIGHT: begin
        body = {2'b00, MSG_LEN} - {5'h00, hdr};
        len_ok = type_ok && body <= {2'b00, n_full};
        sent_nxt = body[3:0];
        // (R15) kill-mask form adds one
        resp_nxt = (typ == `T_KILL) ? `RESP_EIGHT_KILL : `RESP_EIGHT;
      end
      `W_SIXTEEN: begin
        body = {2'b00, MSG_LEN} - {5'h00, hdr};
        len_ok = type_ok && !body[0] && body <= {1'b0, n_full, 1'b0};
        sent_nxt = body[4:1];
        // (R15) minus two per masked channel
        resp_nxt = `RESP_SIXTEEN - {1'b0, nmask, 1'b0};
      end
      default: begin
        // (R18) wide types: header plus one
        wide_e8 = (wtyp == `WT_E8_PS || wtyp == `WT_E8_MD);
        wide_deint = (wtyp == `WT_DEINT);
        wide_unorm = (wtyp == `WT_UNORM_PS || wtyp == `WT_UNORM_MD);
        wide_ok = wide_e8 || wide_deint || wide_unorm
          || wtyp == `WT_UNORM_K_PS || wtyp == `WT_UNORM_K_MD;
        // unknown wide codes fail the length check as well
        len_ok = wide_ok && MSG_LEN == 4'h1 + {3'h0, hdr};
        sent_nxt = 4'h0;
        if (wide_e8) begin
          // (R19) four fewer per masked channel
          resp_nxt = `RESP_E8 - {nmask, 2'b00};
        end else if (wide_unorm) begin
          resp_nxt = `RESP_UNORM - {1'b0, nmask, 1'b0};
        end else if (wide_ok && !wide_deint) begin
          resp_nxt = `RESP_UNORM_KILL - {1'b0, nmask, 1'b0};
        end else begin
          // deinterlace length set by sampler state
          resp_nxt = 5'h00;
        end
      end
    endcase
    // (R9) offsets ignored for unorm, 8x8 and deinterlace
    no_offsets = (width == `W_WIDE);
    if (no_offsets) begin
      offu_nxt = 4'h0;
      offv_nxt = 4'h0;
      offr_nxt = 4'h0;
    end
    // masks ignored for deinterlace; relies on requester for (R8)
    if (wide_deint) begin
      mask_nxt = 4'h0;
    end
  end

  // decoded outputs, registered
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DEC_VALID <= 1'b0;
      LANE_WIDTH <= 2'h0;
      OP_TYPE <= 5'h00;
      SAMPLER_IDX <= 4'h0;
      BIND_IDX <= 8'h00;
      CHAN_MASK <= 4'h0;
      OFF_U <= 4'h0;
      OFF_V <= 4'h0;
      OFF_R <= 4'h0;
      PARAMS_SENT <= 4'h0;
      INT_PARAMS <= 1'b0;
      RESP_LEN <= 5'h00;
      PROTO_ERR <= 1'b0;
    end else begin
      // strobe follows MSG_VALID one cycle later; fields hold until the next request
      DEC_VALID <= MSG_VALID;
      if (MSG_VALID) begin
        // (R1) width passes through
        LANE_WIDTH <= width;
        // (R2) (R16) type identifies operation
        OP_TYPE <= wtyp;
        // (R3) index already zeroed where unused
        SAMPLER_IDX <= samp_nxt;
        // (R5) binding table entry
        BIND_IDX <= DESC[`BTI_HI:`BTI_LO];
        // (R7) masks as sent, zero when no header
        CHAN_MASK <= mask_nxt;
        // (R9) offsets kept as 4-bit two's complement; the core sign-extends
        OFF_U <= offu_nxt;
        OFF_V <= offv_nxt;
        OFF_R <= offr_nxt;
        // (R12) only the count leaves here; the core zero-fills the rest
        PARAMS_SENT <= sent_nxt;
        // (R11) integer class for load and surface info
        INT_PARAMS <= (width != `W_WIDE) && int_p;
        // deinterlace reports zero: its length depends on sampler state
        RESP_LEN <= resp_nxt;
        // (R21) (R14) mismatch or overlong is error
        PROTO_ERR <= ctrl_r[0] && (!len_ok || MSG_LEN > `MAX_MSG_LEN);
      end else begin
        // a pulse beside the strobe, never sticky
        PROTO_ERR <= 1'b0;
      end
    end
  end

  // register writes and status capture
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r <= `CTRL_RST;
      last_desc_r <= `RST_ZERO;
      err_cnt_r <= 16'h0000;
      last_len_r <= 4'h0;
    end else begin
      // whole control word replaced; upper bits have no meaning
      if (WR && ADDR == A_CTRL) begin
        ctrl_r <= WDATA[1:0];
      end
      // kept for software debug of a rejected request
      if (MSG_VALID) begin
        last_desc_r <= DESC;
        last_len_r <= MSG_LEN;
      end
      // counter increment wins over software clear
      if (PROTO_ERR) begin
        err_cnt_r <= err_cnt_r + 16'h0001;
      end else if (WR && ADDR == A_ERR_CNT) begin
        err_cnt_r <= 16'h0000;
      end
    end
  end

  // read data, one cycle after strobe
  // reads have no side effects, so software may poll freely
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= `RST_ZERO;
    end else if (RD) begin
      if (ADDR == A_LAST_DESC) begin
        RDATA <= last_desc_r;
      end else if (ADDR == A_ERR_CNT) begin
        RDATA <= {16'h0000, err_cnt_r};
      end else if (ADDR == A_CTRL) begin
        RDATA <= {30'h0000_0000, ctrl_r};
      end else if (ADDR == A_LAST_LEN) begin
        RDATA <= {28'h000_0000, last_len_r};
      end else begin
        // unmapped reads as zero
        RDATA <= `RST_ZERO;
      end
    end else begin
      RDATA <= `RST_ZERO;
    end
  end
endmodule // sampler_message_decoder
`default_nettype wire

// ==== design/msg_decoder_consts.vh ====
// constants for the sampler message decoder
`ifndef MSG_DECODER_CONSTS_VH
`define MSG_DECODER_CONSTS_VH
// descriptor field positions
`define HDR_PRESENT_BIT 19
`define WIDTH_HI 17
`define WIDTH_LO 16
`define TYPE_HI 15
`define TYPE_LO 12
`define SAMP_HI 11
`define SAMP_LO 8
`define BTI_HI 7
`define BTI_LO 0
// header field positions
`define MASK_A_BIT 15
`define MASK_R_BIT 12
`define OFFU_HI 11
`define OFFU_LO 8
`define OFFV_HI 7
`define OFFV_LO 4
`define OFFR_HI 3
`define OFFR_LO 0
// width encodings
`define W_QUAD 2'h0
`define W_EIGHT 2'h1
`define W_SIXTEEN 2'h2
`define W_WIDE 2'h3
// narrow message types
`define T_SAMPLE 4'h0
`define T_BIAS 4'h1
`define T_LEVEL 4'h2
`define T_CMP 4'h3
`define T_GRAD 4'h4
`define T_BIAS_CMP 4'h5
`define T_LEVEL_CMP 4'h6
`define T_LOAD 4'h7
`define T_GATHER 4'h8
`define T_LODQ 4'h9
`define T_SURFINFO 4'ha
`define T_SAMPINFO 4'hb
`define T_KILL 4'hc
// wide message types (five bits: bit 4 taken as zero)
`define WT_UNORM_PS 5'h00
`define WT_UNORM_K_PS 5'h02
`define WT_E8_PS 5'h03
`define WT_DEINT 5'h08
`define WT_UNORM_MD 5'h0c
`define WT_UNORM_K_MD 5'h0a
`define WT_E8_MD 5'h0b
// lengths
`define MAX_MSG_LEN 4'hb
`define RESP_QUAD 5'h01
`define RESP_EIGHT 5'h04
`define RESP_EIGHT_KILL 5'h05
`define RESP_SIXTEEN 5'h08
`define RESP_UNORM 5'h08
`define RESP_UNORM_KILL 5'h09
`define RESP_E8 5'h10
// register indices on the command port
`define REG_LAST_DESC 4'h0
`define REG_ERR_CNT 4'h1
`define REG_CTRL 4'h2
`define REG_LAST_LEN 4'h3
// control reset value: error detection on, header taken as sent
`define CTRL_RST 2'h1
// zero word for the last-descriptor register and read data
`define RST_ZERO 32'h0000_0000
`endif

// ==== design/param_count.v ====
// parameter count and float/int class per narrow message type
`include "msg_decoder_consts.vh"
`default_nettype none
module param_count (
  input wire [3:0] msg_type,
  output reg [3:0] n_params,
  output reg int_params,
  output reg valid_type
);
  // fixed parameter lists, count of full list per type
  always @* begin
    int_params = 1'b0;
    valid_type = 1'b1;
    case (msg_type)
      `T_SAMPLE: n_params = 4'h4;
      `T_BIAS: n_params = 4'h5;
      `T_LEVEL: n_params = 4'h5;
      `T_CMP: n_params = 4'h5;
      `T_GRAD: n_params = 4'ha;
      `T_BIAS_CMP: n_params = 4'h6;
      `T_LEVEL_CMP: n_params = 4'h6;
      `T_LOAD: begin
        n_params = 4'h5;
        int_params = 1'b1;
      end
      `T_GATHER: n_params = 4'h4;
      `T_LODQ: n_params = 4'h4;
      `T_SURFINFO: begin
        n_params = 4'h1;
        int_params = 1'b1;
      end
      `T_SAMPINFO: n_params = 4'h0;
      `T_KILL: n_params = 4'h3;
      default: begin
        n_params = 4'h0;
        valid_type = 1'b0;
      end
    endcase
  end
endmodule // param_count
`default_nettype wire

// ==== sim/sampler_message_decoder_properties.sv ====
// port-level assertion checker for the sampler message decoder
`default_nettype none
module decoder_checker (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic MSG_VALID,
  input wire logic [31:0] DESC,
  input wire logic [31:0] HEADER,
  input wire logic [3:0] MSG_LEN,
  input wire logic DEC_VALID,
  input wire logic [1:0] LANE_WIDTH,
  input wire logic [3:0] SAMPLER_IDX,
  input wire logic [3:0] CHAN_MASK,
  input wire logic [4:0] RESP_LEN,
  input wire logic PROTO_ERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // control mirror from the write port: enable in bit 0, header override in bit 1
  logic [1:0] ctrl_m;
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_m <= 2'h1;
    end else if (WR && ADDR == 4'h2) begin
      ctrl_m <= WDATA[1:0];
    end
  end
  // narrow width request; wide ones decode masks and index differently
  wire nar = MSG_VALID && DESC[17:16] != 2'h3;
  dec_follows_a: assert property (MSG_VALID |=> DEC_VALID)
    else $error("no decode strobe");
  width_copy_a: assert property (MSG_VALID |=> LANE_WIDTH == $past(DESC[17:16]))
    else $error("lane width wrong");
  samp_zero_a: assert property (nar && DESC[15:12] inside {4'h7, 4'ha, 4'hb} |=> !SAMPLER_IDX)
    else $error("sampler index not ignored");
  no_hdr_a: assert property (MSG_VALID && (!DESC[19] || ctrl_m[1]) |=> CHAN_MASK == 4'h0)
    else $error("mask without header");
  mask_copy_a: assert property (nar && DESC[19] && !ctrl_m[1]
    |=> CHAN_MASK == $past(HEADER[15:12]))
    else $error("channel mask wrong");
  quad_resp_a: assert property (MSG_VALID && DESC[17:16] == 2'h0 |=> RESP_LEN == 5'h01)
    else $error("quad response length wrong");
  long_err_a: assert property (MSG_VALID && MSG_LEN > 4'hb && ctrl_m[0] |=> PROTO_ERR)
    else $error("overlong message not flagged");
  err_off_a: assert property (MSG_VALID && !ctrl_m[0] |=> !PROTO_ERR)
    else $error("error flagged while disabled");
  err_pair_a: assert property (PROTO_ERR |-> DEC_VALID)
    else $error("error without decode");
  cover property (MSG_VALID && DESC[17:16] == 2'h3);
  cover property (PROTO_ERR);
  cover property (MSG_VALID ##1 MSG_VALID);
  cover property (MSG_VALID && ctrl_m[1] && DESC[19]);
endmodule // decoder_checker
bind sampler_message_decoder decoder_checker i_decoder_checker (.REF_CLK(REF_CLK),
  .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .MSG_VALID(MSG_VALID), .DESC(DESC), .HEADER(HEADER), .MSG_LEN(MSG_LEN),
  .DEC_VALID(DEC_VALID), .LANE_WIDTH(LANE_WIDTH), .SAMPLER_IDX(SAMPLER_IDX),
  .CHAN_MASK(CHAN_MASK), .RESP_LEN(RESP_LEN), .PROTO_ERR(PROTO_ERR));
`default_nettype wire

// ==== sim/eu_thread_model.sv ====
// requesting thread model: issues one sampler message per call
`default_nettype none
module eu_thread_model (
  input wire logic clk,
  output logic msg_valid,
  output logic [31:0] desc,
  output logic [31:0] header,
  output logic [3:0] msg_len
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    msg_valid = 1'b0;
    desc = 32'h0000_0000;
    header = 32'h0000_0000;
    msg_len = 4'h0;
  end
  // raises the strobe and leaves it up until idle; bad lets a scenario break the length limit on purpose
  task automatic send(input logic [31:0] d, input logic [31:0] h, input logic [3:0] l,
      input logic bad);
    logic wide;
    wide = d[17:16] == 2'h3;
    if (h[15:12] == 4'hf) h[15] = 1'b0;
    if (wide && d[15:12] == 4'hb) h[15] = 1'b0;
    if (wide && d[15:12] == 4'h8) d[8] = 1'b0;
    if (wide && d[13:12] == 2'h3) d[9:8] = 2'h0;
    // header bit 31 stands for a cube or buffer surface: no offsets then
    if (h[31]) h[11:0] = 12'h000;
    if (!bad && l > 4'hb) l = 4'hb;
    @(posedge clk);
    msg_valid <= 1'b1;
    desc <= d;
    header <= h;
    msg_len <= l;
  endtask
  // released lines flip so a stale copy is never mistaken for data
  task automatic idle();
    @(posedge clk);
    msg_valid <= 1'b0;
    desc <= ~desc;
    header <= ~header;
    msg_len <= ~msg_len;
  endtask
endmodule // eu_thread_model
`default_nettype wire

// ==== sim/sampler_message_decoder_tb.sv ====
// self-checking bench for the sampler message decoder
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module sampler_message_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic dec_valid, int_params, proto_err, msg_valid;
  logic [31:0] rdata, desc, header;
  logic [1:0] lane_width;
  logic [4:0] op_type, resp_len;
  logic [3:0] msg_len, sampler_idx, chan_mask, off_u, off_v, off_r, params_sent;
  logic [7:0] bind_idx;
  int n_mismatch = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  sampler_message_decoder i_sampler_message_decoder (.REF_CLK(clk), .RSTN(rstn), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .MSG_VALID(msg_valid), .DESC(desc),
    .HEADER(header), .MSG_LEN(msg_len), .DEC_VALID(dec_valid), .LANE_WIDTH(lane_width),
    .OP_TYPE(op_type), .SAMPLER_IDX(sampler_idx), .BIND_IDX(bind_idx), .CHAN_MASK(chan_mask),
    .OFF_U(off_u), .OFF_V(off_v), .OFF_R(off_r), .PARAMS_SENT(params_sent),
    .INT_PARAMS(int_params), .RESP_LEN(resp_len), .PROTO_ERR(proto_err));
  eu_thread_model i_eu_thread_model (.clk(clk), .msg_valid(msg_valid), .desc(desc),
    .header(header), .msg_len(msg_len));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // one request, then the outputs every request sets
  task automatic msg(input logic [31:0] d, input logic [31:0] h, input logic [3:0] l,
      input logic [4:0] rl, input logic err);
    i_eu_thread_model.send(d, h, l, err);
    i_eu_thread_model.idle();
    #1 `CHK({dec_valid, proto_err, bind_idx}, {1'b1, err, d[7:0]})
    `CHK(lane_width, d[17:16])
    if (!err) `CHK(resp_len, rl)
  endtask
  task automatic t_widths();
    msg(32'h0008_2011, 32'h0000_0000, 4'h3, 5'h01, 1'b0);
    `CHK(params_sent, 4'h8)
    msg(32'h0001_c022, 32'hffff_ffff, 4'h3, 5'h05, 1'b0);
    `CHK({chan_mask, off_u, off_v, off_r}, 16'h0000)
    msg(32'h000a_0033, 32'h8000_3abc, 4'h9, 5'h04, 1'b0);
    `CHK({chan_mask, off_u, off_v, off_r, params_sent}, 20'h3_0004)
    msg(32'h000a_0033, 32'h0000_0000, 4'h8, 5'h00, 1'b1);
  endtask
  task automatic t_types();
    int nf[13] = '{4, 5, 5, 5, 10, 6, 6, 5, 4, 4, 1, 0, 3};
    for (int t = 0; t < 14; t++) begin
      msg({12'h000, 4'h9, 4'(t), 12'h542}, 32'h0000_9a5f, 4'(t < 13 ? nf[t % 13] + 1 : 1),
        (t == 12) ? 5'h05 : 5'h04, t == 13);
      if (t < 13) begin
        `CHK(op_type, {1'b0, 4'(t)})
        `CHK(sampler_idx, (t == 7 || t == 10 || t == 11) ? 4'h0 : 4'h5)
        `CHK(int_params, (t == 7 || t == 10))
        `CHK(params_sent, 4'(nf[t]))
        `CHK({chan_mask, off_u, off_v, off_r}, 16'h9a5f)
      end
    end
  endtask
  task automatic t_wide();
    logic [3:0] wt[7] = '{4'h0, 4'h2, 4'h3, 4'h8, 4'hc, 4'ha, 4'hb};
    logic [4:0] rl[7] = '{5'h06, 5'h07, 5'h0c, 5'h00, 5'h06, 5'h07, 5'h0c};
    for (int i = 0; i < 7; i++) begin
      msg({12'h000, 4'hb, wt[i], 12'h3ff}, 32'h0000_1abc, 4'h2, rl[i], 1'b0);
      `CHK({chan_mask, off_u}, {(wt[i] == 4'h8) ? 4'h0 : 4'h1, 4'h0})
      `CHK(sampler_idx, (wt[i] == 4'h8) ? 4'h2 : (wt[i][1:0] == 2'h3 ? 4'h0 : 4'h3))
    end
  endtask
  task automatic t_err();
    i_eu_thread_model.send(32'h0001_0000, 32'h0000_0000, 4'hc, 1'b1);
    i_eu_thread_model.send(32'h000b_0000, 32'h0000_0000, 4'h3, 1'b0);
    #1 `CHK(proto_err, 1'b1)
    i_eu_thread_model.idle();
    #1 `CHK(proto_err, 1'b1)
    i_eu_thread_model.idle();
    #1 `CHK({dec_valid, proto_err}, 2'b00)
  endtask
  // header override and error enable both come from the control word
  task automatic t_ctrl();
    wr(4'h2, 32'h0000_0002);
    msg(32'h0009_1000, 32'h0000_1abc, 4'h9, 5'h04, 1'b0);
    `CHK({chan_mask, off_u, off_v, off_r}, 16'h0000)
    wr(4'h2, 32'h0000_0001);
  endtask
  task automatic t_regs();
    wr(4'h1, 32'h0000_0000);
    msg(32'h0001_0000, 32'h0000_0000, 4'hc, 5'h00, 1'b1);
    rd_chk(4'h1, 32'h0000_0001);
    rd_chk(4'h2, 32'h0000_0001);
    rd_chk(4'h3, 32'h0000_000c);
    wr(4'h0, 32'hffff_ffff);
    rd_chk(4'h0, 32'h0001_0000);
    rd_chk(4'hf, 32'h0000_0000);
  endtask
  task automatic report_and_stop();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_widths();
    t_types();
    t_wide();
    t_err();
    t_ctrl();
    t_regs();
    report_and_stop();
  end
  // the run needs about 80 cycles; this is far beyond it
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // sampler_message_decoder_tb
`default_nettype wire
